// *** hw/cstc_cfg.svh ***
`ifndef CSTC_CFG_SVH
`define CSTC_CFG_SVH

// Control word layout
`define CSTC_CTRL_W 16
`define CSTC_SEL_LSB 0
`define CSTC_SEL_MSB 4
`define CSTC_STAT_BIT 6
`define CSTC_TRIG_BIT 7
`define CSTC_CASC_BIT 8
`define CSTC_CTRL_RESET 16'h000d
`define CSTC_CTRL_MASK 16'h01df

// Source codes
`define CSTC_SEL_NONE 5'h00
`define CSTC_SEL_TRIG_ONLY_MIN 5'h18
`define CSTC_SEL_CAP1 5'h10
`define CSTC_SEL_CAP9 5'h0a

// Host register byte offsets
`define CSTC_OFS_CONFIG 12'h000
`define CSTC_OFS_STATUS 12'h004
`define CSTC_OFS_EVENT 12'h008

// Host status bits
`define CSTC_ST_REFUSED 0
`define CSTC_ST_TRIGGERED 1
`define CSTC_ST_CASCADE 2

// Timer limits
`define CSTC_TMR_MAX 16'hffff

`endif

// *** hw/cstc_channel.sv ***
// Design decisions made here: the registered cascade carry between halves and the registered readback of the control word.
`timescale 1ns/1ps
`include "cstc_cfg.svh"

module cstc_channel #(
    parameter int CHANNEL_NUM = 1,
    parameter int TMR_W = 16
) (
    // Link to controller
    cstc_if.channel link,
    // Cascade chain
    input wire logic carry_in,
    output logic carry_out,
    // Timer view
    output logic [TMR_W-1:0] timer_value,
    output logic timer_running
);

    ////////////////////////////////////////////////////////////////////////////
    // Control fields

    logic [4:0] source_select_reg;
    logic sync_or_trigger_select_reg;
    logic trigger_status_reg;
    logic cascade_enable_reg;
    logic [15:0] rdata_reg;
    logic [TMR_W-1:0] timer_reg;
    logic [TMR_W-1:0] timer_next;
    logic carry_reg;
    logic running_reg;

    cstc_pkg::cstc_mode_t mode;
    logic src_fire;
    logic is_high_half;
    logic casc_high;
    logic run_now;
    logic step;
    logic trig_status_next;
    logic trig_hit;
    logic sync_hit;
    logic at_top;
    logic wrap_now;
    logic [15:0] rdata_next;

    // Even channels are the upper half of a cascaded pair
    assign is_high_half = (CHANNEL_NUM % 2) == 0;

    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            source_select_reg <= 5'(`CSTC_CTRL_RESET >> `CSTC_SEL_LSB);
        end else if (link.cfg_wr) begin
            source_select_reg <= link.cfg_wdata[`CSTC_SEL_MSB:`CSTC_SEL_LSB];
        end
    end

    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            sync_or_trigger_select_reg <= 1'b0;
        end else if (link.cfg_wr) begin
            sync_or_trigger_select_reg <= link.cfg_wdata[`CSTC_TRIG_BIT];
        end
    end

    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            cascade_enable_reg <= 1'b0;
        end else if (link.cfg_wr) begin
            cascade_enable_reg <= link.cfg_wdata[`CSTC_CASC_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    always_comb begin
        if (source_select_reg == `CSTC_SEL_NONE) begin
            mode = cstc_pkg::CSTC_FREE;
        end else if (sync_or_trigger_select_reg) begin
            mode = cstc_pkg::CSTC_TRIG;
        end else begin
            mode = cstc_pkg::CSTC_SYNC;
        end
    end

    // Code zero selects no line at all
    assign src_fire = (source_select_reg != `CSTC_SEL_NONE) &&
        link.src_event[source_select_reg];

    // One event, two meanings: start the timer or clear it
    assign trig_hit = (mode == cstc_pkg::CSTC_TRIG) && src_fire;
    assign sync_hit = (mode == cstc_pkg::CSTC_SYNC) && src_fire;

    ////////////////////////////////////////////////////////////////////////////
    // Trigger status

    // Hardware set beats a software clear in the same cycle
    always_comb begin
        trig_status_next = trigger_status_reg;
        if (link.cfg_wr) begin
            trig_status_next = link.cfg_wdata[`CSTC_STAT_BIT];
        end
        if (trig_hit) begin
            trig_status_next = 1'b1;
        end
    end

    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            trigger_status_reg <= 1'b0;
        end else begin
            trigger_status_reg <= trig_status_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer

    assign casc_high = cascade_enable_reg && is_high_half;

    always_comb begin
        if (mode == cstc_pkg::CSTC_TRIG) begin
            run_now = trigger_status_reg;
        end else begin
            run_now = 1'b1;
        end
    end

    // High half only moves on a wrap of its low neighbour
    assign step = casc_high ? carry_in : 1'b1;

    always_comb begin
        timer_next = timer_reg;
        if (!run_now) begin
            timer_next = '0;
        end else if (sync_hit) begin
            timer_next = '0;
        end else if (step) begin
            timer_next = timer_reg + TMR_W'(1);
        end
    end

    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            timer_reg <= '0;
        end else begin
            timer_reg <= timer_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cascade

    // A sync clear at the top value is not a wrap, so it sends no carry
    assign at_top = timer_reg == {TMR_W{1'b1}};
    assign wrap_now = run_now && !sync_hit && step && at_top;

    // Registered wrap; the high half lags its low half by one cycle
    // Pairing is not checked here: software sets the bit in both halves
    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            carry_reg <= 1'b0;
        end else begin
            carry_reg <= cascade_enable_reg && !is_high_half && wrap_now;
        end
    end

    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            running_reg <= 1'b0;
        end else begin
            running_reg <= (mode == cstc_pkg::CSTC_TRIG) ? trig_status_next : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read back

    // Reserved bits read zero
    // Built field by field so the layout follows the header
    always_comb begin
        rdata_next = 16'h0000;
        rdata_next[`CSTC_SEL_MSB:`CSTC_SEL_LSB] = source_select_reg;
        rdata_next[`CSTC_STAT_BIT] = trigger_status_reg;
        rdata_next[`CSTC_TRIG_BIT] = sync_or_trigger_select_reg;
        rdata_next[`CSTC_CASC_BIT] = cascade_enable_reg;
    end

    always_ff @(posedge link.core_clk) begin
        if (!link.rst_n) begin
            rdata_reg <= `CSTC_CTRL_RESET;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign link.cfg_rdata = rdata_reg;
    assign carry_out = carry_reg;
    assign timer_value = timer_reg;
    assign timer_running = running_reg;

endmodule : cstc_channel

// *** hw/cstc_host.sv ***
`timescale 1ns/1ps
`include "cstc_cfg.svh"

module cstc_host #(
    parameter int CHANNEL_NUM = 1
) (
    // Link to channel
    cstc_if.host link,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events from other on-chip modules
    input wire logic [31:0] module_events
);

    ////////////////////////////////////////////////////////////////////////////
    // APB timing: no wait states

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic cfg_wr_reg;
    logic [15:0] cfg_wdata_reg;
    logic [31:0] event_reg;
    logic refused_reg;
    logic setup;
    logic done;
    logic wr_cfg;
    logic wr_stat;
    logic wr_evt;
    logic mapped;
    logic [4:0] own_code;
    logic bad_cfg;
    logic core_clk_w;

    assign core_clk_w = link.core_clk;
    assign setup = psel && !penable;
    assign done = psel && penable && pready_reg;
    assign mapped = (paddr == `CSTC_OFS_CONFIG) || (paddr == `CSTC_OFS_STATUS) ||
        (paddr == `CSTC_OFS_EVENT);
    assign wr_cfg = done && pwrite && (paddr == `CSTC_OFS_CONFIG);
    assign wr_stat = done && pwrite && (paddr == `CSTC_OFS_STATUS);
    assign wr_evt = done && pwrite && (paddr == `CSTC_OFS_EVENT);

    assign own_code = (CHANNEL_NUM == 9) ? `CSTC_SEL_CAP9 :
        5'(`CSTC_SEL_CAP1 + CHANNEL_NUM - 1);

    // Analog sources as sync, or own event as source, are refused
    assign bad_cfg = (pwdata[`CSTC_SEL_MSB:`CSTC_SEL_LSB] >= `CSTC_SEL_TRIG_ONLY_MIN &&
        !pwdata[`CSTC_TRIG_BIT]) ||
        (pwdata[`CSTC_SEL_MSB:`CSTC_SEL_LSB] == own_code);

    always_ff @(posedge core_clk_w) begin
        if (!link.rst_n) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
        end
    end

    always_ff @(posedge core_clk_w) begin
        if (!link.rst_n) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= setup && !mapped;
        end
    end

    always_ff @(posedge core_clk_w) begin
        if (!link.rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            if (paddr == `CSTC_OFS_CONFIG) begin
                prdata_reg <= {16'h0000, link.cfg_rdata};
            end else if (paddr == `CSTC_OFS_STATUS) begin
                prdata_reg <= {29'h0, link.cfg_rdata[`CSTC_CASC_BIT],
                    link.cfg_rdata[`CSTC_STAT_BIT], refused_reg};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Orders to the channel

    always_ff @(posedge core_clk_w) begin
        if (!link.rst_n) begin
            cfg_wr_reg <= 1'b0;
        end else begin
            cfg_wr_reg <= wr_cfg && !bad_cfg;
        end
    end

    always_ff @(posedge core_clk_w) begin
        if (!link.rst_n) begin
            cfg_wdata_reg <= 16'h0000;
        end else if (wr_cfg) begin
            cfg_wdata_reg <= pwdata[15:0] & `CSTC_CTRL_MASK;
        end
    end

    // New refusal wins over a clear in the same cycle
    always_ff @(posedge core_clk_w) begin
        if (!link.rst_n) begin
            refused_reg <= 1'b0;
        end else if (wr_cfg && bad_cfg) begin
            refused_reg <= 1'b1;
        end else if (wr_stat && pwdata[`CSTC_ST_REFUSED]) begin
            refused_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_w) begin
        if (!link.rst_n) begin
            event_reg <= 32'h0000_0000;
        end else begin
            event_reg <= module_events | (wr_evt ? pwdata : 32'h0000_0000);
        end
    end

    assign link.cfg_wr = cfg_wr_reg;
    assign link.cfg_wdata = cfg_wdata_reg;
    assign link.src_event = event_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

endmodule : cstc_host

// *** hw/cstc_if.sv ***
`timescale 1ns/1ps

interface cstc_if (
    input wire logic core_clk,
    input wire logic rst_n
);
    logic cfg_wr;
    logic [15:0] cfg_wdata;
    logic [15:0] cfg_rdata;
    logic [31:0] src_event;

    modport channel (
        input core_clk,
        input rst_n,
        input cfg_wr,
        input cfg_wdata,
        input src_event,
        output cfg_rdata
    );

    modport host (
        input core_clk,
        input rst_n,
        output cfg_wr,
        output cfg_wdata,
        output src_event,
        input cfg_rdata
    );
endinterface : cstc_if

// *** hw/cstc_pkg.sv ***
package cstc_pkg;

    typedef enum logic [1:0] {
        CSTC_FREE,
        CSTC_SYNC,
        CSTC_TRIG
    } cstc_mode_t;

    typedef logic [4:0] cstc_sel_t;

    typedef logic [15:0] cstc_word_t;

endpackage : cstc_pkg

// *** testbench/capture_sync_trigger_control_test.sv ***
`timescale 1ns/1ps

module capture_sync_trigger_control_test;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] module_events = 32'h0;
    logic [15:0] timer_value;
    logic timer_running;
    logic [15:0] hi_value;
    logic carry;
    logic [31:0] rd;
    logic er;
    int err_total = 0;
    int checked = 0;

    always #12.5 core_clk = ~core_clk;

    cstc_if link_inst (.core_clk(core_clk), .rst_n(rst_n));
    cstc_host cstc_host_inst (.link(link_inst.host), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .module_events(module_events));
    // Odd channel is the low half, so nothing carries into it
    cstc_channel cstc_channel_inst (.link(link_inst.channel), .carry_in(1'b0),
        .carry_out(carry), .timer_value(timer_value), .timer_running(timer_running));
    // Even neighbour shares the bus, so one write configures the pair
    cstc_if link_pair_inst (.core_clk(core_clk), .rst_n(rst_n));
    cstc_host #(.CHANNEL_NUM(2)) cstc_host_pair_inst (.link(link_pair_inst.host),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(), .pready(), .pslverr(), .module_events(module_events));
    cstc_channel #(.CHANNEL_NUM(2)) cstc_channel_pair_inst (.link(link_pair_inst.channel),
        .carry_in(carry), .carry_out(), .timer_value(hi_value), .timer_running());
    cstc_assertions cstc_assertions_inst (.core_clk(core_clk), .rst_n(rst_n),
        .cfg_wr(link_inst.cfg_wr), .cfg_wdata(link_inst.cfg_wdata),
        .cfg_rdata(link_inst.cfg_rdata), .src_event(link_inst.src_event));

    ////////////////////////////////////////////////////////////////////////////////
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task finish_test();
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // One idle edge before setup keeps consecutive calls from double driving
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the control word reach the readback path
        if (w) repeat (4) @(posedge core_clk);
    endtask : apb

    task t_codes();
        for (int i = 0; i < 32; i++) begin
            if (i != 16) begin
                apb(12'h000, 1'b1, 32'h80 | i);
                apb(12'h000, 1'b0, 32'h0);
                chk("code", rd, 32'h80 | i);
            end
        end
    endtask : t_codes

    task t_trig();
        apb(12'h000, 1'b1, 32'h0183);
        chk("held", {timer_running, timer_value}, 32'h0);
        apb(12'h004, 1'b0, 32'h0);
        chk("casc", rd[2:1], 2'b10);
        apb(12'h008, 1'b1, 32'h8);
        chk("run", timer_running, 1'b1);
        chk("moving", timer_value != 16'h0, 1'b1);
        apb(12'h000, 1'b0, 32'h0);
        chk("stat", rd, 32'h01c3);
        apb(12'h000, 1'b1, 32'h0085);
        chk("rearm", {timer_running, timer_value}, 32'h0);
        apb(12'h000, 1'b1, 32'h00c5);
        chk("sw", timer_running, 1'b1);
    endtask : t_trig

    task t_sync_free();
        apb(12'h000, 1'b1, 32'h0004);
        repeat (40) @(posedge core_clk);
        module_events <= 32'h10;
        @(posedge core_clk);
        module_events <= 32'h0;
        repeat (5) @(posedge core_clk);
        chk("sync", timer_value < 16'h0008, 1'b1);
        apb(12'h000, 1'b1, 32'h0000);
        repeat (20) @(posedge core_clk);
        module_events <= 32'hffffffff;
        @(posedge core_clk);
        module_events <= 32'h0;
        repeat (5) @(posedge core_clk);
        chk("free", timer_value > 16'h0020, 1'b1);
    endtask : t_sync_free

    task t_refuse();
        apb(12'h000, 1'b1, 32'h0018);
        apb(12'h004, 1'b0, 32'h0);
        chk("ana", rd[0], 1'b1);
        apb(12'h004, 1'b1, 32'h1);
        apb(12'h000, 1'b1, 32'h0090);
        apb(12'h000, 1'b0, 32'h0);
        chk("keep", rd, 32'h0000);
        apb(12'h004, 1'b1, 32'h1);
        apb(12'h004, 1'b0, 32'h0);
        chk("w1c", rd[0], 1'b0);
    endtask : t_refuse

    // Sync both halves to zero, then run the low half through one full wrap
    task t_cascade();
        apb(12'h000, 1'b1, 32'h0104);
        module_events <= 32'h10;
        @(posedge core_clk);
        module_events <= 32'h0;
        repeat (2) @(posedge core_clk);
        while (timer_value !== 16'hffff) @(posedge core_clk);
        chk("hold", hi_value, 16'h0000);
        @(posedge core_clk);
        chk("carry", carry, 1'b1);
        @(posedge core_clk);
        chk("high", hi_value, 16'h0001);
        apb(12'h000, 1'b1, 32'h0004);
        chk("alone", hi_value > 16'h0001, 1'b1);
    endtask : t_cascade

    initial begin
        repeat (90000) @(posedge core_clk);
        err_total++;
        finish_test();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(12'h000, 1'b0, 32'h0);
        chk("reset", rd, 32'h000d);
        apb(12'h0f0, 1'b0, 32'h0);
        chk("unmap", {er, rd}, {1'b1, 32'h0});
        t_codes();
        t_trig();
        t_sync_free();
        t_refuse();
        t_cascade();
        finish_test();
    end
endmodule : capture_sync_trigger_control_test

// *** testbench/cstc_assertions.sv ***
`timescale 1ns/1ps

module cstc_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link signals
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic [15:0] cfg_rdata,
    input wire logic [31:0] src_event
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Readback lags state by one edge, so every check except a_spare_zero looks two edges ahead
    property p_spare_zero;
        cfg_rdata[15:9] == 7'h00 && !cfg_rdata[5];
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("spare control bits set");

    property p_sel_load;
        cfg_wr ##1 !cfg_wr |=> cfg_rdata[4:0] == $past(cfg_wdata[4:0], 2);
    endproperty
    a_sel_load: assert property (p_sel_load) else $error("source field not loaded");

    property p_mode_load;
        cfg_wr ##1 !cfg_wr |=> cfg_rdata[8:7] == $past(cfg_wdata[8:7], 2);
    endproperty
    a_mode_load: assert property (p_mode_load) else $error("mode bits not loaded");

    property p_trig_fire;
        cfg_rdata[7] && cfg_rdata[4:0] != 5'h00 && !cfg_wr && !$past(cfg_wr)
            && src_event[cfg_rdata[4:0]] |-> ##2 cfg_rdata[6];
    endproperty
    a_trig_fire: assert property (p_trig_fire) else $error("trigger did not set status");

    property p_trig_sticky;
        cfg_rdata[7] && cfg_rdata[6] && !cfg_wr && !$past(cfg_wr) |-> ##2 cfg_rdata[6];
    endproperty
    a_trig_sticky: assert property (p_trig_sticky) else $error("status dropped alone");

    property p_trig_wait;
        cfg_rdata[7] && !cfg_rdata[6] && !cfg_wr && !$past(cfg_wr)
            && src_event == 32'h0 && $past(src_event) == 32'h0 |-> ##2 !cfg_rdata[6];
    endproperty
    a_trig_wait: assert property (p_trig_wait) else $error("status set without event");

    property p_free_status;
        cfg_rdata[4:0] == 5'h00 && !cfg_wr && !$past(cfg_wr)
            |-> ##2 cfg_rdata[6] == $past(cfg_rdata[6], 2);
    endproperty
    a_free_status: assert property (p_free_status) else $error("free mode status moved");

    property p_sync_status;
        !cfg_rdata[7] && cfg_rdata[4:0] != 5'h00 && !cfg_wr && !$past(cfg_wr)
            |-> ##2 cfg_rdata[6] == $past(cfg_rdata[6], 2);
    endproperty
    a_sync_status: assert property (p_sync_status) else $error("sync mode status moved");

    c_write: cover property (cfg_wr);
    c_fire: cover property (cfg_rdata[7] && !cfg_rdata[6] && src_event != 32'h0);
    c_sync: cover property (!cfg_rdata[7] && cfg_rdata[4:0] != 5'h00 && src_event != 32'h0);
endmodule : cstc_assertions
